/* logic/sstsel_trigger.v */
// sequence state-one trigger selector with register port
//
// Contract
// - code 0 gives no trigger; with jump also 0 state one holds.
// - codes 1..5 use digital input one..five, high is active.
// - codes -1..-5 use inputs one..five inverted, low is active.
// - code 6 fires when analog one is below first low.
// - code 7 fires when analog one is above first high.
// - codes 8, 9: analog two below first low, above first high.
// - code 10 fires when either analog input is below first low.
// - code 11: analog one below first low and two above high.
// - codes 12, 13: first-pair compare ORed with input five.
// - codes 14..17 repeat single compares on second pair.
// - code 18 fires when either analog is below second low.
// - code 19: analog one below second low, two above high.
// - codes 20, 21: second-pair compare ORed with input five.
// - codes 22..25 use timed function one..four.
// - code 26 fires only when the state delay has elapsed.
// - codes 27..31: input one..five active or delay elapsed.
// - code 32: analog one above first high or delay elapsed.
// - code 33: analog one below first low or delay elapsed.
// - delay 0..6553.5 s in 0.1 s steps gates every exit; clearing program start still leaves state one at once.
// - jump trigger beats next-state trigger when both fire.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "sstsel_consts.vh"
module sstsel_trigger #(
  parameter AW = 16,
  parameter [31:0] TICK_CYCLES = `SSTS_TICK_CYCLES
) (
  input wire clk_sys, // system clock, 125 MHz
  input wire resetn, // synchronous reset, active low
  input wire [7:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, cycle after strobe
  input wire digital_input_one, // pin, asynchronous
  input wire digital_input_two, // pin, asynchronous
  input wire digital_input_three, // pin, asynchronous
  input wire digital_input_four, // pin, asynchronous
  input wire digital_input_five, // pin, asynchronous
  input wire [AW-1:0] analog_input_one, // scaled sample
  input wire [AW-1:0] analog_input_two, // scaled sample
  input wire timed_function_one_output, // timed function
  input wire timed_function_two_output, // timed function
  input wire timed_function_three_output, // timed function
  input wire timed_function_four_output, // timed function
  output reg [7:0] seq_state, // current sequence state
  output reg advance_pulse, // one cycle on move to state two
  output reg jump_pulse // one cycle on jump to state n
);
  localparam [7:0] ST_STOP = `SSTS_ST_STOP;
  localparam [7:0] ST_ONE = `SSTS_ST_ONE;
  localparam [7:0] ST_TWO = `SSTS_ST_TWO;

  reg sequence_program_start_r;
  reg [7:0] state_one_next_trigger_select_r;
  reg [7:0] state_one_jump_trigger_select_r;
  reg [7:0] state_one_jump_target_r;
  reg [15:0] state_one_delay_time_r;
  reg [AW-1:0] first_low_threshold_r;
  reg [AW-1:0] first_high_threshold_r;
  reg [AW-1:0] second_low_threshold_r;
  reg [AW-1:0] second_high_threshold_r;
  reg [4:0] din_meta_r;
  reg [4:0] din_sync_r;
  reg [31:0] tick_cnt_r;
  reg step_tick_r;
  reg [15:0] dly_ticks_r;
  reg [7:0] state_nxt;
  reg [31:0] rdata_nxt;
  wire [4:0] din_pins;
  wire [3:0] timed_fn;
  wire in_one;
  wire dly_done;
  wire next_hit;
  wire jump_hit;

  assign din_pins = {digital_input_five, digital_input_four,
    digital_input_three, digital_input_two, digital_input_one};
  assign timed_fn = {timed_function_four_output,
    timed_function_three_output, timed_function_two_output,
    timed_function_one_output};
  assign in_one = (seq_state == ST_ONE);

  // widen a threshold-width value onto the 32-bit read bus
  function [31:0] sstsel_widen;
    input [AW-1:0] val;
    begin
      sstsel_widen = 32'h0000_0000;
      sstsel_widen[AW-1:0] = val;
    end
  endfunction

  // two-stage synchroniser; only the second stage feeds logic
  always @(posedge clk_sys) begin
    if (!resetn) begin
      din_meta_r <= 5'h00;
      din_sync_r <= 5'h00;
    end else begin
      din_meta_r <= din_pins;
      din_sync_r <= din_meta_r;
    end
  end

  // register writes; unmapped addresses are ignored
  always @(posedge clk_sys) begin
    if (!resetn) begin
      sequence_program_start_r <= 1'b0;
      state_one_next_trigger_select_r <= `SSTS_RST_SEL;
      state_one_jump_trigger_select_r <= `SSTS_RST_SEL;
      state_one_jump_target_r <= `SSTS_RST_TGT;
      state_one_delay_time_r <= `SSTS_RST_DELAY;
      first_low_threshold_r <= `SSTS_RST_THR;
      first_high_threshold_r <= `SSTS_RST_THR;
      second_low_threshold_r <= `SSTS_RST_THR;
      second_high_threshold_r <= `SSTS_RST_THR;
    end else if (reg_wr) begin
      case (reg_addr)
        `SSTS_ADDR_CTRL: begin
          sequence_program_start_r <= reg_wdata[`SSTS_CTRL_RUN_BIT];
        end
        `SSTS_ADDR_NEXT_SEL: begin
          state_one_next_trigger_select_r <= reg_wdata[7:0];
        end
        `SSTS_ADDR_JUMP_SEL: begin
          state_one_jump_trigger_select_r <= reg_wdata[7:0];
        end
        `SSTS_ADDR_JUMP_TGT: begin
          state_one_jump_target_r <= reg_wdata[7:0];
        end
        `SSTS_ADDR_DELAY: begin
          state_one_delay_time_r <= reg_wdata[15:0];
        end
        `SSTS_ADDR_LO1: begin
          first_low_threshold_r <= reg_wdata[AW-1:0];
        end
        `SSTS_ADDR_HI1: begin
          first_high_threshold_r <= reg_wdata[AW-1:0];
        end
        `SSTS_ADDR_LO2: begin
          second_low_threshold_r <= reg_wdata[AW-1:0];
        end
        `SSTS_ADDR_HI2: begin
          second_high_threshold_r <= reg_wdata[AW-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // tenth-second step divider
  // restarts on leaving state one so the first step is a full 0.1 s
  always @(posedge clk_sys) begin
    if (!resetn) begin
      tick_cnt_r <= 32'h0000_0000;
      step_tick_r <= 1'b0;
    end else if (!in_one) begin
      tick_cnt_r <= 32'h0000_0000;
      step_tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_CYCLES - 32'h0000_0001) begin
      tick_cnt_r <= 32'h0000_0000;
      step_tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      step_tick_r <= 1'b0;
    end
  end

  // elapsed steps in state one
  // saturates, so a full-scale delay of 6553.5 s still completes
  always @(posedge clk_sys) begin
    if (!resetn) begin
      dly_ticks_r <= 16'h0000;
    end else if (!in_one) begin
      dly_ticks_r <= 16'h0000;
    end else if (step_tick_r && dly_ticks_r != 16'hFFFF) begin
      dly_ticks_r <= dly_ticks_r + 16'h0001;
    end
  end

  assign dly_done = (dly_ticks_r >= state_one_delay_time_r);

  // both selectors see the same synced inputs each cycle
  sstsel_cond #(
    .AW(AW)
  ) u_next_cond (
    .sel_code(state_one_next_trigger_select_r),
    .din(din_sync_r),
    .ain_one(analog_input_one),
    .ain_two(analog_input_two),
    .lo_one(first_low_threshold_r),
    .hi_one(first_high_threshold_r),
    .lo_two(second_low_threshold_r),
    .hi_two(second_high_threshold_r),
    .timed_fn(timed_fn),
    .dly_done(dly_done),
    .hit(next_hit)
  );

  sstsel_cond #(
    .AW(AW)
  ) u_jump_cond (
    .sel_code(state_one_jump_trigger_select_r),
    .din(din_sync_r),
    .ain_one(analog_input_one),
    .ain_two(analog_input_two),
    .lo_one(first_low_threshold_r),
    .hi_one(first_high_threshold_r),
    .lo_two(second_low_threshold_r),
    .hi_two(second_high_threshold_r),
    .timed_fn(timed_fn),
    .dly_done(dly_done),
    .hit(jump_hit)
  );

  // next state; states past one hold until program start is cleared
  always @* begin
    state_nxt = seq_state;
    case (seq_state)
      ST_STOP: begin
        if (sequence_program_start_r) begin
          state_nxt = ST_ONE;
        end
      end
      ST_ONE: begin
        if (dly_done) begin
          if (jump_hit) begin
            state_nxt = state_one_jump_target_r;
          end else if (next_hit) begin
            state_nxt = ST_TWO;
          end
        end
      end
      default: begin
        state_nxt = seq_state;
      end
    endcase
    // only clearing program start releases a frozen state
    if (!sequence_program_start_r) begin
      state_nxt = ST_STOP;
    end
  end

  // one transition per cycle; a pulse marks each trigger exit from state one
  always @(posedge clk_sys) begin
    if (!resetn) begin
      seq_state <= ST_STOP;
      advance_pulse <= 1'b0;
      jump_pulse <= 1'b0;
    end else begin
      seq_state <= state_nxt;
      advance_pulse <= in_one && sequence_program_start_r &&
        dly_done && !jump_hit && next_hit;
      jump_pulse <= in_one && sequence_program_start_r &&
        dly_done && jump_hit;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (reg_addr)
      `SSTS_ADDR_CTRL: begin
        rdata_nxt[`SSTS_CTRL_RUN_BIT] = sequence_program_start_r;
      end
      `SSTS_ADDR_NEXT_SEL: begin
        rdata_nxt[7:0] = state_one_next_trigger_select_r;
      end
      `SSTS_ADDR_JUMP_SEL: begin
        rdata_nxt[7:0] = state_one_jump_trigger_select_r;
      end
      `SSTS_ADDR_JUMP_TGT: begin
        rdata_nxt[7:0] = state_one_jump_target_r;
      end
      `SSTS_ADDR_DELAY: begin
        rdata_nxt[15:0] = state_one_delay_time_r;
      end
      `SSTS_ADDR_LO1: rdata_nxt = sstsel_widen(first_low_threshold_r);
      `SSTS_ADDR_HI1: rdata_nxt = sstsel_widen(first_high_threshold_r);
      `SSTS_ADDR_LO2: rdata_nxt = sstsel_widen(second_low_threshold_r);
      `SSTS_ADDR_HI2: rdata_nxt = sstsel_widen(second_high_threshold_r);
      `SSTS_ADDR_STATUS: begin
        rdata_nxt[`SSTS_STAT_STATE_LSB +: 8] = seq_state;
        rdata_nxt[`SSTS_STAT_DLY_BIT] = in_one & dly_done;
        rdata_nxt[`SSTS_STAT_NEXT_BIT] = next_hit;
        rdata_nxt[`SSTS_STAT_JUMP_BIT] = jump_hit;
        rdata_nxt[`SSTS_STAT_DIN_LSB +: 5] = din_sync_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // read data stand one cycle only, zero otherwise
  always @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule // sstsel_trigger

/* logic/sstsel_consts.vh */
// constants for the sequence state-one trigger selector
`ifndef SSTSEL_CONSTS_VH
`define SSTSEL_CONSTS_VH
// register byte offsets
`define SSTS_ADDR_CTRL 8'h00
`define SSTS_ADDR_NEXT_SEL 8'h04
`define SSTS_ADDR_JUMP_SEL 8'h08
`define SSTS_ADDR_JUMP_TGT 8'h0C
`define SSTS_ADDR_DELAY 8'h10
`define SSTS_ADDR_LO1 8'h14
`define SSTS_ADDR_HI1 8'h18
`define SSTS_ADDR_LO2 8'h1C
`define SSTS_ADDR_HI2 8'h20
`define SSTS_ADDR_STATUS 8'h24
// field positions
`define SSTS_CTRL_RUN_BIT 0
`define SSTS_STAT_STATE_LSB 0
`define SSTS_STAT_DLY_BIT 8
`define SSTS_STAT_NEXT_BIT 9
`define SSTS_STAT_JUMP_BIT 10
`define SSTS_STAT_DIN_LSB 16
// reset values
`define SSTS_RST_SEL 8'h00
`define SSTS_RST_TGT 8'h03
`define SSTS_RST_DELAY 16'h0000
`define SSTS_RST_THR 16'h0000
// sequence states
`define SSTS_ST_STOP 8'h00
`define SSTS_ST_ONE 8'h01
`define SSTS_ST_TWO 8'h02
// delay step 0.1 s in ns, clock period in ns
`define SSTS_STEP_NS 32'h05F5_E100
`define SSTS_CLK_NS 32'h0000_0008
`define SSTS_TICK_CYCLES (`SSTS_STEP_NS / `SSTS_CLK_NS)
// selection codes, two's complement
`define SSTS_SEL_DI5_INV 8'hFB
`define SSTS_SEL_DI4_INV 8'hFC
`define SSTS_SEL_DI3_INV 8'hFD
`define SSTS_SEL_DI2_INV 8'hFE
`define SSTS_SEL_DI1_INV 8'hFF
`define SSTS_SEL_NONE 8'h00
`define SSTS_SEL_DI1 8'h01
`define SSTS_SEL_DI2 8'h02
`define SSTS_SEL_DI3 8'h03
`define SSTS_SEL_DI4 8'h04
`define SSTS_SEL_DI5 8'h05
`define SSTS_SEL_A1_LO1 8'h06
`define SSTS_SEL_A1_HI1 8'h07
`define SSTS_SEL_A2_LO1 8'h08
`define SSTS_SEL_A2_HI1 8'h09
`define SSTS_SEL_AX_LO1 8'h0A
`define SSTS_SEL_A1LO_A2HI1 8'h0B
`define SSTS_SEL_A1LO1_D5 8'h0C
`define SSTS_SEL_A2HI1_D5 8'h0D
`define SSTS_SEL_A1_LO2 8'h0E
`define SSTS_SEL_A1_HI2 8'h0F
`define SSTS_SEL_A2_LO2 8'h10
`define SSTS_SEL_A2_HI2 8'h11
`define SSTS_SEL_AX_LO2 8'h12
`define SSTS_SEL_A1LO_A2HI2 8'h13
`define SSTS_SEL_A1LO2_D5 8'h14
`define SSTS_SEL_A2HI2_D5 8'h15
`define SSTS_SEL_TF1 8'h16
`define SSTS_SEL_TF2 8'h17
`define SSTS_SEL_TF3 8'h18
`define SSTS_SEL_TF4 8'h19
`define SSTS_SEL_DLY 8'h1A
`define SSTS_SEL_DI1_DLY 8'h1B
`define SSTS_SEL_DI2_DLY 8'h1C
`define SSTS_SEL_DI3_DLY 8'h1D
`define SSTS_SEL_DI4_DLY 8'h1E
`define SSTS_SEL_DI5_DLY 8'h1F
`define SSTS_SEL_A1HI1_DLY 8'h20
`define SSTS_SEL_A1LO1_DLY 8'h21
`endif

/* logic/sstsel_cond.v */
// trigger condition decoder for one selection code
`timescale 1ns/10ps
`include "sstsel_consts.vh"
module sstsel_cond #(
  parameter AW = 16
) (
  input wire [7:0] sel_code, // selection code
  input wire [4:0] din, // synced digital inputs, bit 0 = input one
  input wire [AW-1:0] ain_one, // analog input one
  input wire [AW-1:0] ain_two, // analog input two
  input wire [AW-1:0] lo_one, // first low threshold
  input wire [AW-1:0] hi_one, // first high threshold
  input wire [AW-1:0] lo_two, // second low threshold
  input wire [AW-1:0] hi_two, // second high threshold
  input wire [3:0] timed_fn, // timed function outputs
  input wire dly_done, // state delay elapsed
  output reg hit // selected condition is true
);
  // strict comparisons, values and thresholds share one scale
  wire a1_lo1 = ain_one < lo_one;
  wire a1_hi1 = ain_one > hi_one;
  wire a2_lo1 = ain_two < lo_one;
  wire a2_hi1 = ain_two > hi_one;
  wire a1_lo2 = ain_one < lo_two;
  wire a1_hi2 = ain_one > hi_two;
  wire a2_lo2 = ain_two < lo_two;
  wire a2_hi2 = ain_two > hi_two;

  // code decode; codes 34 and up give no trigger
  always @* begin
    case (sel_code)
      `SSTS_SEL_DI1_INV: hit = ~din[0];
      `SSTS_SEL_DI2_INV: hit = ~din[1];
      `SSTS_SEL_DI3_INV: hit = ~din[2];
      `SSTS_SEL_DI4_INV: hit = ~din[3];
      `SSTS_SEL_DI5_INV: hit = ~din[4];
      `SSTS_SEL_NONE: hit = 1'b0;
      `SSTS_SEL_DI1: hit = din[0];
      `SSTS_SEL_DI2: hit = din[1];
      `SSTS_SEL_DI3: hit = din[2];
      `SSTS_SEL_DI4: hit = din[3];
      `SSTS_SEL_DI5: hit = din[4];
      `SSTS_SEL_A1_LO1: hit = a1_lo1;
      `SSTS_SEL_A1_HI1: hit = a1_hi1;
      `SSTS_SEL_A2_LO1: hit = a2_lo1;
      `SSTS_SEL_A2_HI1: hit = a2_hi1;
      `SSTS_SEL_AX_LO1: hit = a1_lo1 | a2_lo1;
      `SSTS_SEL_A1LO_A2HI1: hit = a1_lo1 & a2_hi1;
      `SSTS_SEL_A1LO1_D5: hit = a1_lo1 | din[4];
      `SSTS_SEL_A2HI1_D5: hit = a2_hi1 | din[4];
      `SSTS_SEL_A1_LO2: hit = a1_lo2;
      `SSTS_SEL_A1_HI2: hit = a1_hi2;
      `SSTS_SEL_A2_LO2: hit = a2_lo2;
      `SSTS_SEL_A2_HI2: hit = a2_hi2;
      `SSTS_SEL_AX_LO2: hit = a1_lo2 | a2_lo2;
      `SSTS_SEL_A1LO_A2HI2: hit = a1_lo2 & a2_hi2;
      `SSTS_SEL_A1LO2_D5: hit = a1_lo2 | din[4];
      `SSTS_SEL_A2HI2_D5: hit = a2_hi2 | din[4];
      `SSTS_SEL_TF1: hit = timed_fn[0];
      `SSTS_SEL_TF2: hit = timed_fn[1];
      `SSTS_SEL_TF3: hit = timed_fn[2];
      `SSTS_SEL_TF4: hit = timed_fn[3];
      `SSTS_SEL_DLY: hit = dly_done;
      `SSTS_SEL_DI1_DLY: hit = din[0] | dly_done;
      `SSTS_SEL_DI2_DLY: hit = din[1] | dly_done;
      `SSTS_SEL_DI3_DLY: hit = din[2] | dly_done;
      `SSTS_SEL_DI4_DLY: hit = din[3] | dly_done;
      `SSTS_SEL_DI5_DLY: hit = din[4] | dly_done;
      `SSTS_SEL_A1HI1_DLY: hit = a1_hi1 | dly_done;
      `SSTS_SEL_A1LO1_DLY: hit = a1_lo1 | dly_done;
      default: hit = 1'b0;
    endcase
  end
endmodule // sstsel_cond

/* verif/sstsel_far_model.sv */
// far-side model: digital pins, analog samples and timed functions
`timescale 1ns/10ps
module sstsel_far_model (
  input wire clk_sys, // system clock
  input wire [4:0] din_cmd, // wanted pin levels, bit 0 = input one
  input wire [15:0] a1_cmd, // wanted analog one sample
  input wire [15:0] a2_cmd, // wanted analog two sample
  input wire [3:0] tf_cmd, // wanted timed levels, bit 0 = one
  output reg digital_input_one = 1'b0, // pin one
  output reg digital_input_two = 1'b0, // pin two
  output reg digital_input_three = 1'b0, // pin three
  output reg digital_input_four = 1'b0, // pin four
  output reg digital_input_five = 1'b0, // pin five
  output reg [15:0] analog_input_one = 16'h0000, // sample one
  output reg [15:0] analog_input_two = 16'h0000, // sample two
  output reg timed_function_one_output = 1'b0, // timed one
  output reg timed_function_two_output = 1'b0, // timed two
  output reg timed_function_three_output = 1'b0, // timed three
  output reg timed_function_four_output = 1'b0 // timed four
);
  // values move only on an edge, so the sync depth is seen exactly
  always @(posedge clk_sys) begin
    {digital_input_five, digital_input_four, digital_input_three,
      digital_input_two, digital_input_one} <= din_cmd;
    analog_input_one <= a1_cmd;
    analog_input_two <= a2_cmd;
    {timed_function_four_output, timed_function_three_output,
      timed_function_two_output, timed_function_one_output} <= tf_cmd;
  end
endmodule // sstsel_far_model

/* verif/sstsel_trigger_props.sv */
// assertions on the ports of the state-one trigger selector
`timescale 1ns/10ps
`include "sstsel_consts.vh"
module sstsel_trigger_props #(
  parameter AW = 16,
  parameter [31:0] TICK_CYCLES = 32'h0000_0004
) (
  input wire clk_sys, // system clock
  input wire resetn, // synchronous reset, active low
  input wire [7:0] reg_addr, // register address
  input wire [31:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire [7:0] seq_state, // sequence state
  input wire advance_pulse, // move to state two
  input wire jump_pulse // jump to state n
);
  reg [15:0] dly_r;
  reg [31:0] stay_r;
  wire [47:0] dly_cycles = dly_r * TICK_CYCLES;
  wire ctrl_wr = reg_wr && reg_addr == `SSTS_ADDR_CTRL;
  // shadow the delay and count edges spent in state one
  always @(posedge clk_sys) begin
    if (!resetn) begin
      dly_r <= 16'h0000;
      stay_r <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `SSTS_ADDR_DELAY)
        dly_r <= reg_wdata[15:0];
      stay_r <= (seq_state == 8'h01) ? stay_r + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_adv_once; advance_pulse |=> !advance_pulse; endproperty
  a_adv_once: assert property (p_adv_once)
    else $error("advance pulse longer than one cycle");
  property p_adv_move;
    advance_pulse |-> seq_state == 8'h02 && $past(seq_state) == 8'h01;
  endproperty
  a_adv_move: assert property (p_adv_move)
    else $error("advance pulse without move from one to two");
  property p_move_flag;
    $past(seq_state) == 8'h01 && seq_state == 8'h02 |->
      advance_pulse || jump_pulse;
  endproperty
  a_move_flag: assert property (p_move_flag)
    else $error("state two entered without a pulse");
  property p_one_kind; not (advance_pulse && jump_pulse); endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("both exits taken at once");
  property p_jump_src; jump_pulse |-> $past(seq_state) == 8'h01; endproperty
  a_jump_src: assert property (p_jump_src)
    else $error("jump pulse outside state one");
  property p_delay_gate;
    advance_pulse || jump_pulse |-> stay_r >= dly_cycles;
  endproperty
  a_delay_gate: assert property (p_delay_gate)
    else $error("exit before the state delay elapsed");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside the read cycle");
  property p_run_enter;
    ctrl_wr && reg_wdata[0] && seq_state == 8'h00 |-> ##[1:2]
      seq_state == 8'h01;
  endproperty
  a_run_enter: assert property (p_run_enter)
    else $error("program start did not enter state one");
  property p_stop;
    ctrl_wr && !reg_wdata[0] |-> ##[1:2] seq_state == 8'h00;
  endproperty
  a_stop: assert property (p_stop)
    else $error("clearing start did not stop the sequence");
  property p_hold;
    seq_state > 8'h01 && !ctrl_wr && !$past(ctrl_wr) |=> $stable(seq_state);
  endproperty
  a_hold: assert property (p_hold)
    else $error("later state moved without a start change");
  // main scenarios
  c_adv: cover property (advance_pulse);
  c_jump: cover property (jump_pulse);
  c_late: cover property (advance_pulse && dly_r != 16'h0000);
endmodule // sstsel_trigger_props
bind sstsel_trigger sstsel_trigger_props #(.AW(AW),
  .TICK_CYCLES(TICK_CYCLES)) u_props (.clk_sys, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .seq_state, .advance_pulse,
  .jump_pulse);

/* verif/sstsel_trigger_bench.sv */
// self-checking bench for the state-one trigger selector
`timescale 1ns/10ps
`include "sstsel_consts.vh"
`define CHK(g, e) check(g, e)
module sstsel_trigger_bench;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0000_0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [4:0] din_cmd = 5'h00;
  reg [15:0] a1_cmd = 16'h0000;
  reg [15:0] a2_cmd = 16'h0000;
  reg [3:0] tf_cmd = 4'h0;
  reg [3:0] tf_v = 4'h0;
  wire [31:0] reg_rdata;
  wire [7:0] seq_state;
  wire advance_pulse, jump_pulse;
  wire digital_input_one, digital_input_two, digital_input_three;
  wire digital_input_four, digital_input_five;
  wire [15:0] analog_input_one, analog_input_two;
  wire timed_function_one_output, timed_function_two_output;
  wire timed_function_three_output, timed_function_four_output;
  integer num_errors = 0;
  integer n_tests = 0;
  integer n;
  reg [31:0] d;
  reg [7:0] k;
  reg [4:0] b;
  sstsel_far_model u_far (.clk_sys, .din_cmd, .a1_cmd, .a2_cmd, .tf_cmd,
    .digital_input_one, .digital_input_two, .digital_input_three,
    .digital_input_four, .digital_input_five, .analog_input_one,
    .analog_input_two, .timed_function_one_output,
    .timed_function_two_output, .timed_function_three_output,
    .timed_function_four_output);
  sstsel_trigger #(.AW(16), .TICK_CYCLES(32'h0000_0004)) u_dut (.clk_sys,
    .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .digital_input_one, .digital_input_two, .digital_input_three,
    .digital_input_four, .digital_input_five, .analog_input_one,
    .analog_input_two, .timed_function_one_output,
    .timed_function_two_output, .timed_function_three_output,
    .timed_function_four_output, .seq_state, .advance_pulse, .jump_pulse);
  // 125 MHz
  initial forever #4 clk_sys = ~clk_sys;
  task check(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task final_report;
    begin
      $display("mismatches %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
    end
  endtask
  // samples: low, mid, high, exactly first low, exactly first high
  function [15:0] av(input [3:0] s);
    case (s)
      4'h0: av = 16'h0032;
      4'h1: av = 16'h01F4;
      4'h2: av = 16'h0BB8;
      4'h3: av = 16'h0064;
      default: av = 16'h00C8;
    endcase
  endfunction
  // set the far side, select a code, then read the condition flag
  task tc(input [7:0] c, input [4:0] di, input [7:0] xy, input e);
    begin
      @(posedge clk_sys);
      din_cmd <= di;
      a1_cmd <= av(xy[7:4]);
      a2_cmd <= av(xy[3:0]);
      tf_cmd <= tf_v;
      wr(`SSTS_ADDR_NEXT_SEL, {24'h00_0000, c});
      repeat (4) @(posedge clk_sys);
      rd(`SSTS_ADDR_STATUS, d);
      `CHK(d[`SSTS_STAT_NEXT_BIT], e);
    end
  endtask
  // a bounded wait, the hang guard of the sequencer runs
  task wait_exit(input integer lim);
    begin
      n = 0;
      while (advance_pulse !== 1'b1 && jump_pulse !== 1'b1 && n < lim) begin
        @(posedge clk_sys);
        #1 n = n + 1;
      end
      if (n >= lim) begin
        num_errors = num_errors + 1;
        final_report;
      end
    end
  endtask
  task run_seq(input [7:0] c, input [7:0] j, input [15:0] dl,
    input [7:0] es, input integer lo, input integer hi);
    begin
      wr(`SSTS_ADDR_DELAY, {16'h0000, dl});
      wr(`SSTS_ADDR_NEXT_SEL, {24'h00_0000, c});
      wr(`SSTS_ADDR_JUMP_SEL, {24'h00_0000, j});
      wr(`SSTS_ADDR_CTRL, 32'h0000_0001);
      wait_exit(80);
      `CHK(seq_state, {24'h00_0000, es});
      `CHK({advance_pulse, jump_pulse}, (es == 8'h02) ? 2'h2 : 2'h1);
      `CHK(n >= lo && n <= hi, 1'b1);
      wr(`SSTS_ADDR_CTRL, 32'h0000_0000);
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    // reset values, the unmapped hole and the read-only status
    for (k = 8'h00; k < 8'h2C; k = k + 8'h04) begin
      rd(k, d);
      `CHK(d, (k == `SSTS_ADDR_JUMP_TGT) ? 32'h0000_0003 : 32'h0000_0000);
    end
    wr(8'h28, 32'hFFFF_FFFF);
    rd(8'h28, d);
    `CHK(d, 32'h0000_0000);
    wr(`SSTS_ADDR_STATUS, 32'hFFFF_FFFF);
    rd(`SSTS_ADDR_STATUS, d);
    `CHK(d, 32'h0000_0000);
    wr(`SSTS_ADDR_LO1, 32'h0000_0064);
    wr(`SSTS_ADDR_HI1, 32'h0000_00C8);
    wr(`SSTS_ADDR_LO2, 32'h0000_03E8);
    wr(`SSTS_ADDR_HI2, 32'h0000_07D0);
    rd(`SSTS_ADDR_HI2, d);
    `CHK(d, 32'h0000_07D0);
    // park in state one behind a long delay so the table never exits
    wr(`SSTS_ADDR_DELAY, 32'h0000_FFFF);
    wr(`SSTS_ADDR_CTRL, 32'h0000_0001);
    for (k = 8'h00; k < 8'h05; k = k + 8'h01) begin
      b = 5'h01 << k;
      tc(k + 8'h01, b, 8'h11, 1'b1);
      tc(k + 8'h01, ~b, 8'h11, 1'b0);
      tc(8'hFF - k, ~b, 8'h11, 1'b1);
      tc(8'hFF - k, b, 8'h11, 1'b0);
      tc(k + 8'h1B, b, 8'h11, 1'b1);
      tc(k + 8'h1B, ~b, 8'h11, 1'b0);
    end
    for (k = 8'h00; k < 8'h04; k = k + 8'h01) begin
      tf_v = 4'h1 << k;
      tc(k + 8'h16, 5'h00, 8'h11, 1'b1);
      tf_v = ~(4'h1 << k);
      tc(k + 8'h16, 5'h00, 8'h11, 1'b0);
    end
    tf_v = 4'h0;
    tc(8'h06, 5'h00, 8'h01, 1'b1);
    tc(8'h06, 5'h00, 8'h31, 1'b0);
    tc(8'h07, 5'h00, 8'h21, 1'b1);
    tc(8'h07, 5'h00, 8'h41, 1'b0);
    tc(8'h08, 5'h00, 8'h10, 1'b1);
    tc(8'h08, 5'h00, 8'h01, 1'b0);
    tc(8'h09, 5'h00, 8'h12, 1'b1);
    tc(8'h09, 5'h00, 8'h14, 1'b0);
    tc(8'h0A, 5'h00, 8'h10, 1'b1);
    tc(8'h0A, 5'h00, 8'h11, 1'b0);
    tc(8'h0B, 5'h00, 8'h02, 1'b1);
    tc(8'h0B, 5'h00, 8'h04, 1'b0);
    tc(8'h0C, 5'h10, 8'h11, 1'b1);
    tc(8'h0C, 5'h0F, 8'h11, 1'b0);
    tc(8'h0D, 5'h00, 8'h12, 1'b1);
    tc(8'h0D, 5'h00, 8'h14, 1'b0);
    tc(8'h0E, 5'h00, 8'h12, 1'b1);
    tc(8'h0F, 5'h00, 8'h12, 1'b0);
    tc(8'h0F, 5'h00, 8'h21, 1'b1);
    tc(8'h10, 5'h00, 8'h21, 1'b1);
    tc(8'h11, 5'h00, 8'h21, 1'b0);
    tc(8'h11, 5'h00, 8'h12, 1'b1);
    tc(8'h12, 5'h00, 8'h21, 1'b1);
    tc(8'h12, 5'h00, 8'h22, 1'b0);
    tc(8'h13, 5'h00, 8'h12, 1'b1);
    tc(8'h13, 5'h00, 8'h11, 1'b0);
    tc(8'h14, 5'h10, 8'h21, 1'b1);
    tc(8'h14, 5'h00, 8'h21, 1'b0);
    tc(8'h15, 5'h10, 8'h11, 1'b1);
    tc(8'h15, 5'h00, 8'h11, 1'b0);
    tc(8'h20, 5'h00, 8'h21, 1'b1);
    tc(8'h20, 5'h00, 8'h41, 1'b0);
    tc(8'h21, 5'h00, 8'h01, 1'b1);
    tc(8'h21, 5'h00, 8'h11, 1'b0);
    tc(8'h1A, 5'h1F, 8'h02, 1'b0);
    tc(8'h22, 5'h1F, 8'h02, 1'b0);
    tc(8'hFA, 5'h00, 8'h02, 1'b0);
    tc(8'h00, 5'h1F, 8'h02, 1'b0);
    rd(`SSTS_ADDR_STATUS, d);
    `CHK(d[`SSTS_STAT_DLY_BIT], 1'b0);
    // no trigger and no jump: state one holds until start is cleared
    wr(`SSTS_ADDR_DELAY, 32'h0000_0000);
    repeat (20) @(posedge clk_sys);
    rd(`SSTS_ADDR_STATUS, d);
    `CHK(d[`SSTS_STAT_DLY_BIT], 1'b1);
    `CHK(seq_state, 8'h01);
    wr(`SSTS_ADDR_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk_sys);
    `CHK(seq_state, 8'h00);
    din_cmd <= 5'h01;
    a1_cmd <= av(4'h2);
    run_seq(8'h07, 8'h00, 16'h0000, 8'h02, 1, 3);
    run_seq(8'h1A, 8'h00, 16'h0003, 8'h02, 12, 16);
    run_seq(8'h1B, 8'h00, 16'h0002, 8'h02, 8, 12);
    run_seq(8'h07, 8'h07, 16'h0000, 8'h03, 1, 3);
    final_report;
  end
endmodule // sstsel_trigger_bench
